// [core/mmcd_pkg.sv]
package mmcd_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 10;
   localparam int SETTLE_NS = 1000;
   localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
   // ----------------------------------------
   // Register port
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam int CTRL_CLEAR_BIT = 0;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] RANGE_AUTO = 8'h00;
   localparam logic [7:0] RANGE_MIN = 8'h01;
   localparam logic [7:0] RANGE_MAX = 8'h0B;
   localparam logic [7:0] RANGE_CANCEL = 8'h0C;
   localparam logic [7:0] PARAM_OFF = 8'h00;
   localparam logic [7:0] PARAM_ON = 8'h01;
   localparam logic [7:0] PARAM_SAT = 8'hFF;
   localparam logic [3:0] RANGE_RESET = 4'hB;
   localparam int QDEPTH = 4;
   // ----------------------------------------
   // Characters
   // ----------------------------------------
   localparam logic [7:0] CH_EXEC = 8'h58;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_Z = 8'h5A;
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_RANGE = 8'h52;
   localparam logic [7:0] CH_CHECK = 8'h43;
   localparam logic [7:0] CH_CORR = 8'h5A;
   localparam logic [7:0] CH_SUPP = 8'h4E;
   localparam logic [7:0] CH_DISP = 8'h44;
   localparam logic [7:0] CH_FUNC = 8'h46;
   localparam logic [7:0] CH_TRIG = 8'h54;
   // ----------------------------------------
   // Readings
   // ----------------------------------------
   localparam int RD_W = 48;
   localparam logic [47:0] FS_BASE = 48'h0000_0000_07D0;
   localparam logic [47:0] DECADE = 48'h0000_0000_000A;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      K_OTHER, K_RANGE, K_CHECK, K_CORR, K_SUPP, K_DISP, K_FUNC, K_TRIG
   } mmcd_kind_t;
   typedef struct packed {
      mmcd_kind_t kind;
      logic [7:0] param;
   } mmcd_cmd_t;
   typedef struct packed {
      logic [20:0] rsvd;
      logic busy;
      logic overrange;
      logic display_source;
      logic suppress;
      logic zero_correct;
      logic zero_check;
      logic auto_range;
      logic [3:0] range;
   } mmcd_status_t;
endpackage : mmcd_pkg

// [core/mmcd_decoder.sv]
`timescale 1ns/1ps
// Operation
// - Reset or clear selects automatic ranging
// - Range 0 auto, 1-11 fixed, 12 cancels
// - Fixed range command leaves automatic ranging
// - Range command ready after range settles
// - Zero check 0 off, 1 on
// - Zero correct 0 off, 1 on
// - Correct with check on captures offset
// - Correct with check off keeps offset
// - Ready on reading done or settling
// - Reset or clear: check on, correct off
// - Queued commands execute strictly in order
// - Suppress enable captures next conversion
// - Suppressed reading is corrected input minus baseline
// - Overrange judged after baseline subtraction
// - Autorange steps up for suppressed reading
// - Range below baseline reports overrange
// - Function change cancels suppression
// - Display 0 meter, 1 source value
// - Reset or clear shows meter reading
// - Electrometer commands revert display to meter
module mmcd_decoder (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Bus interface side
   input wire logic dev_clear_in,
   input wire logic char_valid_in,
   input wire logic [7:0] char_in,
   output logic char_ready_out,
   output logic ready_out,
   // Conversion engine
   input wire logic conv_done_in,
   input wire logic signed [47:0] conv_data_in,
   output logic signed [47:0] reading_out,
   output logic overrange_out,
   // Mode outputs
   output mmcd_pkg::mmcd_status_t mode_out,
   output logic signed [47:0] offset_out,
   output logic signed [47:0] baseline_out,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [47:0] range_cap(input logic [3:0] r);
      logic [47:0] c;
      c = mmcd_pkg::FS_BASE;
      for (int i = 2; i <= 11; i++) begin
         if (i <= int'(r)) begin
            c = c * mmcd_pkg::DECADE;
         end
      end
      return c;
   endfunction : range_cap

   function automatic logic [47:0] mag(input logic signed [47:0] v);
      return v[47] ? 48'(-v) : 48'(v);
   endfunction : mag

   function automatic mmcd_pkg::mmcd_kind_t decode_letter(input logic [7:0] c);
      unique case (c)
         mmcd_pkg::CH_RANGE: return mmcd_pkg::K_RANGE;
         mmcd_pkg::CH_CHECK: return mmcd_pkg::K_CHECK;
         mmcd_pkg::CH_CORR: return mmcd_pkg::K_CORR;
         mmcd_pkg::CH_SUPP: return mmcd_pkg::K_SUPP;
         mmcd_pkg::CH_DISP: return mmcd_pkg::K_DISP;
         mmcd_pkg::CH_FUNC: return mmcd_pkg::K_FUNC;
         mmcd_pkg::CH_TRIG: return mmcd_pkg::K_TRIG;
         default: return mmcd_pkg::K_OTHER;
      endcase
   endfunction : decode_letter

   typedef enum {S_IDLE, S_POP, S_SETTLE, S_CONV} mmcd_state_t;
   typedef enum {W_NONE, W_OFFSET, W_BASE} mmcd_wait_t;

   mmcd_state_t state;
   mmcd_wait_t wait_kind;
   mmcd_pkg::mmcd_cmd_t queue [mmcd_pkg::QDEPTH];
   logic [1:0] q_head;
   logic [1:0] q_tail;
   logic [2:0] q_count;
   mmcd_pkg::mmcd_cmd_t cur;
   logic cur_has;
   logic [7:0] settle_cnt;
   logic [3:0] range;
   logic auto_range;
   logic zero_check;
   logic zero_correct;
   logic suppress;
   logic display_source;
   logic signed [47:0] offset;
   logic signed [47:0] baseline;
   logic over_meas;
   logic clear;
   logic accept;
   logic is_letter;
   logic is_digit;
   logic push;
   logic pop;
   logic go_exec;
   mmcd_pkg::mmcd_cmd_t head;
   logic signed [47:0] corrected;
   logic signed [47:0] next_reading;
   logic [47:0] cap;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   assign clear = rst_in | dev_clear_in |
      (reg_wr_in && reg_addr_in == mmcd_pkg::CTRL_ADDR &&
       reg_wdata_in[mmcd_pkg::CTRL_CLEAR_BIT]);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in && reg_addr_in == mmcd_pkg::STATUS_ADDR) begin
         reg_rdata_out <= mode_out;
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Character parser
   // ----------------------------------------
   assign char_ready_out = (state == S_IDLE);
   assign accept = char_valid_in && char_ready_out;
   assign is_letter = char_in >= mmcd_pkg::CH_A && char_in <= mmcd_pkg::CH_Z;
   assign is_digit = char_in >= mmcd_pkg::CH_0 && char_in <= mmcd_pkg::CH_9;
   assign push = accept && is_letter && cur_has && q_count < 3'(mmcd_pkg::QDEPTH);
   assign go_exec = accept && char_in == mmcd_pkg::CH_EXEC;

   always_ff @(posedge clk_in) begin
      if (clear) begin
         cur_has <= 1'b0;
         cur <= '0;
      end else if (accept && char_in == mmcd_pkg::CH_EXEC) begin
         cur_has <= 1'b0;
      end else if (accept && is_letter) begin
         cur_has <= 1'b1;
         cur.kind <= decode_letter(char_in);
         cur.param <= mmcd_pkg::PARAM_OFF;
      end else if (accept && is_digit && cur_has) begin
         if (cur.param > mmcd_pkg::PARAM_SAT / 8'h0A - 8'h01) begin
            cur.param <= mmcd_pkg::PARAM_SAT;
         end else begin
            cur.param <= 8'(cur.param * 8'h0A + (char_in - mmcd_pkg::CH_0));
         end
      end
   end

   // ----------------------------------------
   // Command queue
   // ----------------------------------------
   assign pop = (state == S_POP) && q_count != 3'h0;
   assign head = queue[q_head];

   always_ff @(posedge clk_in) begin
      if (clear) begin
         q_head <= 2'h0;
         q_tail <= 2'h0;
         q_count <= 3'h0;
      end else if (push) begin
         queue[q_tail] <= cur;
         q_tail <= q_tail + 2'h1;
         q_count <= q_count + 3'h1;
      end else if (pop) begin
         q_head <= q_head + 2'h1;
         q_count <= q_count - 3'h1;
      end
   end

   // ----------------------------------------
   // Execution sequencer
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (clear) begin
         state <= S_IDLE;
         wait_kind <= W_NONE;
         settle_cnt <= 8'h00;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (go_exec) begin
                  state <= S_POP;
               end
            end
            S_POP: begin
               if (q_count == 3'h0) begin
                  state <= S_IDLE;
               end else if (head.kind == mmcd_pkg::K_RANGE ||
                            head.kind == mmcd_pkg::K_CHECK) begin
                  state <= S_SETTLE;
                  settle_cnt <= mmcd_pkg::SETTLE_CYC;
               end else if (head.kind == mmcd_pkg::K_CORR) begin
                  state <= S_CONV;
                  wait_kind <= (head.param == mmcd_pkg::PARAM_ON && zero_check) ?
                     W_OFFSET : W_NONE;
               end else if (head.kind == mmcd_pkg::K_SUPP &&
                            head.param == mmcd_pkg::PARAM_ON) begin
                  state <= S_CONV;
                  wait_kind <= W_BASE;
               end
            end
            S_SETTLE: begin
               settle_cnt <= settle_cnt - 8'h01;
               if (settle_cnt == 8'h01) begin
                  state <= S_POP;
               end
            end
            S_CONV: begin
               if (conv_done_in) begin
                  state <= S_POP;
                  wait_kind <= W_NONE;
               end
            end
         endcase
      end
   end

   assign ready_out = (state == S_IDLE);

   // ----------------------------------------
   // Mode state
   // ----------------------------------------
   assign corrected = zero_correct ? 48'(conv_data_in - offset) : conv_data_in;
   assign next_reading = suppress ? 48'(corrected - baseline) : corrected;
   assign cap = range_cap(range);

   always_ff @(posedge clk_in) begin
      if (clear) begin
         auto_range <= 1'b1;
         range <= mmcd_pkg::RANGE_RESET;
         zero_check <= 1'b1;
         zero_correct <= 1'b0;
         suppress <= 1'b0;
         display_source <= 1'b0;
      end else if (pop) begin
         if (head.kind != mmcd_pkg::K_DISP && head.kind != mmcd_pkg::K_OTHER) begin
            display_source <= 1'b0;
         end
         unique case (head.kind)
            mmcd_pkg::K_RANGE: begin
               if (head.param == mmcd_pkg::RANGE_AUTO) begin
                  auto_range <= 1'b1;
               end else if (head.param == mmcd_pkg::RANGE_CANCEL) begin
                  auto_range <= 1'b0;
               end else if (head.param <= mmcd_pkg::RANGE_MAX) begin
                  auto_range <= 1'b0;
                  range <= head.param[3:0];
               end
            end
            mmcd_pkg::K_CHECK: begin
               if (head.param == mmcd_pkg::PARAM_OFF) zero_check <= 1'b0;
               if (head.param == mmcd_pkg::PARAM_ON) zero_check <= 1'b1;
            end
            mmcd_pkg::K_CORR: begin
               if (head.param == mmcd_pkg::PARAM_OFF) zero_correct <= 1'b0;
               if (head.param == mmcd_pkg::PARAM_ON) zero_correct <= 1'b1;
            end
            mmcd_pkg::K_SUPP: begin
               if (head.param == mmcd_pkg::PARAM_OFF) suppress <= 1'b0;
            end
            mmcd_pkg::K_DISP: begin
               if (head.param == mmcd_pkg::PARAM_OFF) display_source <= 1'b0;
               if (head.param == mmcd_pkg::PARAM_ON) display_source <= 1'b1;
            end
            mmcd_pkg::K_FUNC: suppress <= 1'b0;
            default: begin
            end
         endcase
      end else if (state == S_CONV && conv_done_in && wait_kind == W_BASE) begin
         suppress <= 1'b1;
      end else if (conv_done_in && auto_range) begin
         // Step up on overrange, down when reading fits a decade lower
         if ((mag(next_reading) > cap || (suppress && mag(baseline) > cap)) &&
             range < mmcd_pkg::RANGE_RESET) begin
            range <= range + 4'h1;
         end else if (mag(next_reading) < cap / mmcd_pkg::DECADE &&
                      range > mmcd_pkg::RANGE_MIN[3:0] &&
                      !(suppress && mag(baseline) > cap / mmcd_pkg::DECADE)) begin
            range <= range - 4'h1;
         end
      end
   end

   // Offset and baseline captures; offset survives a device clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         offset <= '0;
         baseline <= '0;
      end else if (state == S_CONV && conv_done_in) begin
         if (wait_kind == W_OFFSET) offset <= conv_data_in;
         if (wait_kind == W_BASE) baseline <= corrected;
      end
   end

   // ----------------------------------------
   // Readings
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reading_out <= '0;
         over_meas <= 1'b0;
         overrange_out <= 1'b0;
      end else begin
         if (conv_done_in) begin
            reading_out <= next_reading;
            over_meas <= mag(next_reading) > cap;
         end
         overrange_out <= over_meas || (suppress && mag(baseline) > cap);
      end
   end

   always_comb begin
      mode_out = '0;
      mode_out.busy = (state != S_IDLE);
      mode_out.overrange = overrange_out;
      mode_out.display_source = display_source;
      mode_out.suppress = suppress;
      mode_out.zero_correct = zero_correct;
      mode_out.zero_check = zero_check;
      mode_out.auto_range = auto_range;
      mode_out.range = range;
   end
   assign offset_out = offset;
   assign baseline_out = baseline;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_clear_modes: assert property (@(posedge clk_in) disable iff (rst_in)
      dev_clear_in |=> auto_range && zero_check && !zero_correct && !display_source)
      else $error("modes wrong after device clear");
   a_range_fixed: assert property (@(posedge clk_in) disable iff (clear)
      pop && head.kind == mmcd_pkg::K_RANGE && head.param == 8'h03
      |=> !auto_range && range == 4'h3)
      else $error("fixed range not taken");
   // Cycles since the last range command, held once past the settle time
   logic [7:0] range_wait;

   always_ff @(posedge clk_in) begin
      if (clear) begin
         range_wait <= 8'h00;
      end else if (pop && head.kind == mmcd_pkg::K_RANGE) begin
         range_wait <= 8'h01;
      end else if (range_wait != 8'h00 && range_wait <= mmcd_pkg::SETTLE_CYC) begin
         range_wait <= range_wait + 8'h01;
      end
   end

   a_range_settle: assert property (@(posedge clk_in) disable iff (clear)
      range_wait != 8'h00 && range_wait <= mmcd_pkg::SETTLE_CYC |-> !ready_out)
      else $error("ready before range settled");
   a_offset_keep: assert property (@(posedge clk_in) disable iff (rst_in)
      pop && head.kind == mmcd_pkg::K_CORR && !zero_check
      |=> $stable(offset) && wait_kind != W_OFFSET)
      else $error("offset changed with zero check off");
   a_offset_take: assert property (@(posedge clk_in) disable iff (rst_in)
      state == S_CONV && wait_kind == W_OFFSET && conv_done_in
      |=> offset == $past(conv_data_in))
      else $error("offset not captured");
   a_exec_order: assert property (@(posedge clk_in) disable iff (clear)
      state != S_IDLE |-> !char_ready_out && !push)
      else $error("characters taken while executing");
   a_supp_diff: assert property (@(posedge clk_in) disable iff (rst_in)
      conv_done_in && suppress
      |=> reading_out == 48'($past(conv_data_in) - ($past(zero_correct) ? $past(offset) : 48'sh0)
                             - $past(baseline)))
      else $error("suppressed reading wrong");
   a_base_over: assert property (@(posedge clk_in) disable iff (rst_in)
      suppress && mag(baseline) > cap ##1 suppress && $stable(baseline) && $stable(range)
      |-> overrange_out)
      else $error("overrange missing below baseline");
   a_func_clear: assert property (@(posedge clk_in) disable iff (clear)
      pop && head.kind == mmcd_pkg::K_FUNC |=> !suppress && !display_source)
      else $error("function change kept suppression");
endmodule : mmcd_decoder

// [tb/mmcd_host_model.sv]
`timescale 1ns/1ps
module mmcd_host_model (
   // Clock
   input wire logic clk_in,
   // Character handshake
   input wire logic char_ready_in,
   output logic char_valid_out,
   output logic [7:0] char_out
);
   initial begin
      char_valid_out = 1'b0;
      char_out = 8'h00;
   end

   // ----------------------------------------
   // Command string sender
   // ----------------------------------------
   // Each character is held until the edge that takes it
   task automatic send(input string s, output bit ok);
      string t;
      int n;
      t = s;
      ok = 1'b1;
      if (t.len() == 0 || t[t.len() - 1] != mmcd_pkg::CH_EXEC) begin
         t = {t, "X"};
      end
      for (int i = 0; i < t.len(); i++) begin
         char_valid_out <= 1'b1;
         char_out <= t[i];
         n = 0;
         do begin
            @(negedge clk_in);
            n++;
         end while (char_ready_in !== 1'b1 && n < 3000);
         if (char_ready_in !== 1'b1) begin
            ok = 1'b0;
            break;
         end
         @(posedge clk_in);
      end
      // Released line shows the inverse of the last character
      char_valid_out <= 1'b0;
      char_out <= ~t[t.len() - 1];
   endtask : send
endmodule : mmcd_host_model

// [tb/mmcd_decoder_bench.sv]
`timescale 1ns/1ps
module mmcd_decoder_bench;
   logic clk_in;
   logic rst_in;
   logic dev_clear_in;
   logic char_valid_in;
   logic [7:0] char_in;
   logic char_ready_out;
   logic ready_out;
   logic conv_done_in;
   logic signed [47:0] conv_data_in;
   logic signed [47:0] reading_out;
   logic overrange_out;
   mmcd_pkg::mmcd_status_t mode_out;
   logic signed [47:0] offset_out;
   logic signed [47:0] baseline_out;
   logic [7:0] reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic reg_wr_in;
   logic reg_rd_in;
   logic [31:0] reg_rdata_out;
   logic signed [47:0] conv_val;
   logic conv_en;
   logic [5:0] conv_cnt;
   int errors;
   int n_tests;
   int cyc;
   string elec [7] = '{"D0X", "F0X", "R2X", "C0X", "Z1X", "N0X", "T1X"};

   mmcd_decoder dut (.clk_in(clk_in), .rst_in(rst_in), .dev_clear_in(dev_clear_in),
      .char_valid_in(char_valid_in), .char_in(char_in), .char_ready_out(char_ready_out),
      .ready_out(ready_out), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
      .reading_out(reading_out), .overrange_out(overrange_out), .mode_out(mode_out),
      .offset_out(offset_out), .baseline_out(baseline_out), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out));

   mmcd_host_model host (.clk_in(clk_in), .char_ready_in(char_ready_out),
      .char_valid_out(char_valid_in), .char_out(char_in));

   always #5 clk_in = ~clk_in;

   // ----------------------------------------
   // Conversion engine: one result every 64 cycles
   // ----------------------------------------
   always @(posedge clk_in) begin
      conv_cnt <= conv_cnt + 6'h01;
      conv_done_in <= conv_en && conv_cnt == 6'h3F;
      conv_data_in <= conv_val;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   task automatic fail(input string msg);
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
   endtask : fail

   task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %0h expected %0h", what, got, exp));
   endtask : chk_val

   function automatic logic [31:0] st(input logic [3:0] rng, input logic [5:0] f);
      return {22'h000000, f, rng};
   endfunction : st

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      n_tests++;
      if (reg_rdata_out !== exp) fail($sformatf("read %0h got %0h", a, reg_rdata_out));
   endtask : reg_read

   // Sends a string and waits, bounded, until the queue has run
   task automatic run(input string s, output int c);
      bit ok;
      @(posedge clk_in);
      host.send(s, ok);
      @(negedge clk_in);
      chk_val(48'(mode_out.busy), 48'h1, "busy after execute");
      c = 1;
      do begin
         @(negedge clk_in);
         c++;
      end while ((ready_out !== 1'b1 || c < 3) && c < 5000);
      if (!ok || ready_out !== 1'b1) begin
         fail($sformatf("no completion of %s", s));
         summarize();
      end
   endtask : run

   task automatic next_conv;
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(negedge clk_in);
            n++;
         end while (conv_done_in !== 1'b1 && n < 200);
         if (n >= 200) begin
            fail("no conversion");
            summarize();
         end
      end
      // Overrange follows the reading by one cycle
      repeat (2) @(negedge clk_in);
   endtask : next_conv

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      dev_clear_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0000_0000;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      conv_val = 48'sh0;
      conv_en = 1'b0;
      conv_cnt = 6'h00;
      errors = 0;
      n_tests = 0;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      reg_read(mmcd_pkg::STATUS_ADDR, st(mmcd_pkg::RANGE_RESET, 6'h03));
      reg_read(8'h08, 32'h0000_0000);
      for (int r = 1; r <= 11; r++) begin
         run($sformatf("R%0dX", r), cyc);
         chk_val(48'(cyc >= int'(mmcd_pkg::SETTLE_CYC)), 48'h1, "settle");
         reg_read(mmcd_pkg::STATUS_ADDR, st(4'(r), 6'h02));
      end
      run("R0X", cyc);
      chk_val(48'(mode_out.auto_range), 48'h1, "auto");
      run("R12X", cyc);
      chk_val(48'(mode_out.auto_range), 48'h0, "cancel auto");
      // Zeroing as one string while conversions run
      conv_en <= 1'b1;
      conv_val <= 48'sh7;
      run("C1XZ1XC0X", cyc);
      chk_val(offset_out, 48'sh7, "offset");
      chk_val(48'(mode_out[6:4]), 48'h4, "modes");
      conv_val <= 48'sh6B;
      next_conv();
      chk_val(reading_out, 48'sh64, "corrected");
      // Baseline on fixed range 2
      run("R2X", cyc);
      conv_val <= 48'sh7 - 48'sh1388;
      next_conv();
      run("T5XN0XN1X", cyc);
      chk_val(baseline_out, -48'sh1388, "baseline");
      chk_val(48'(mode_out.suppress), 48'h1, "suppress");
      conv_val <= 48'sh7 + 48'sh3E80;
      next_conv();
      chk_val(reading_out, 48'sh5208, "suppressed");
      chk_val(48'(overrange_out), 48'h1, "over after baseline");
      conv_val <= 48'sh7 - 48'sh125C;
      next_conv();
      chk_val(reading_out, 48'sh12C, "suppressed");
      chk_val(48'(overrange_out), 48'h0, "in range");
      run("R1X", cyc);
      conv_val <= 48'sh7 - 48'sh1388;
      next_conv();
      chk_val(48'(overrange_out), 48'h1, "range below baseline");
      run("F0X", cyc);
      chk_val(48'(mode_out.suppress), 48'h0, "function change");
      // Display reverts on every electrometer command
      conv_val <= 48'sh39;
      foreach (elec[i]) begin
         run("D1X", cyc);
         chk_val(48'(mode_out.display_source), 48'h1, "source shown");
         run(elec[i], cyc);
         chk_val(48'(mode_out.display_source), 48'h0, "meter shown");
      end
      chk_val(offset_out, 48'sh7, "offset kept");
      // Clear through the register port, then by the bus clear
      conv_en <= 1'b0;
      run("C0XD1X", cyc);
      reg_write(mmcd_pkg::CTRL_ADDR, 32'h0000_0001);
      reg_read(mmcd_pkg::STATUS_ADDR, st(mmcd_pkg::RANGE_RESET, 6'h03));
      run("C0XD1X", cyc);
      @(posedge clk_in);
      dev_clear_in <= 1'b1;
      @(posedge clk_in);
      dev_clear_in <= 1'b0;
      reg_read(mmcd_pkg::STATUS_ADDR, st(mmcd_pkg::RANGE_RESET, 6'h03));
      summarize();
   end
endmodule : mmcd_decoder_bench
